//--- logic/tps_arm_sel.sv
// Arming source selection, edge qualification and the internal trigger timer.
// Assumes the trigger lines are already synchronous to clk.
module tps_arm_sel
  import tps_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 ext_in,
  input  wire logic [ECL_LINES-1:0] ecl_in,
  input  wire logic [TTL_LINES-1:0] ttl_in,
  input  tps_cfg_t                  cfg,
  output tps_arm_t                  arm
);

  logic             prev_ff;
  logic             nxt_prev;
  logic [CNT_W-1:0] tcnt_ff;
  logic [CNT_W-1:0] nxt_tcnt;
  logic             lvl;
  logic             pll_hit;

  always_comb begin
    lvl = 1'b0;
    if (cfg.arm_src == AS_EXT_IN) begin
      lvl = ext_in;
    end else if (cfg.arm_src == AS_ECL) begin
      lvl = ecl_in[cfg.arm_line[0]];
    end else if (cfg.arm_src == AS_TTL) begin
      lvl = ttl_in[cfg.arm_line];
    end
    nxt_prev = lvl;
    // The internal timer free-runs so that internal triggers keep a fixed period.
    pll_hit  = 1'b0;
    nxt_tcnt = tcnt_ff + CNT_ONE;
    if (tcnt_ff + CNT_ONE >= cfg.trig_period) begin
      nxt_tcnt = CNT_RST;
      pll_hit  = 1'b1;
    end
    arm.level = lvl;
    if (cfg.arm_src == AS_PLL) begin
      arm.edge_hit = pll_hit;
    end else begin
      case (cfg.edge_sel)
        ED_RISE: arm.edge_hit = lvl & ~prev_ff;
        ED_FALL: arm.edge_hit = ~lvl & prev_ff;
        default: arm.edge_hit = lvl ^ prev_ff;
      endcase
    end
    case (cfg.gate_lvl)
      GL_HIGH: arm.gate_on = lvl;
      GL_LOW:  arm.gate_on = ~lvl;
      default: arm.gate_on = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_ff <= 1'b0;
      tcnt_ff <= CNT_RST;
    end else if (ce) begin
      prev_ff <= nxt_prev;
      tcnt_ff <= nxt_tcnt;
    end
  end

endmodule : tps_arm_sel

//--- logic/tps_chan.sv
// One output channel: places single, double, RZ or NRZ pulses inside a period.
// Assumes pstart and data_bit arrive together, one cycle per period start.
module tps_chan
  import tps_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             pstart,
  input  wire logic             data_bit,
  input  wire logic             ext_level,
  input  tps_chan_cfg_t         ccfg,
  input  wire logic [CNT_W-1:0] eff_width,
  input  tps_pulse_mode_t       pmode,
  input  tps_trig_mode_t        tmode,
  output logic                  pulse_out
);

  logic [TIME_W-1:0] t_ff;
  logic [TIME_W-1:0] nxt_t;
  logic              act_ff;
  logic              nxt_act;
  logic              bit_ff;
  logic              nxt_bit;
  logic              nxt_out;
  logic [SUM_W-1:0]  tt;
  logic [SUM_W-1:0]  d1;
  logic [SUM_W-1:0]  d2;
  logic [SUM_W-1:0]  ww;
  logic              win1;
  logic              win2;

  always_comb begin
    nxt_t   = t_ff;
    nxt_act = act_ff;
    nxt_bit = bit_ff;
    if (pstart) begin
      nxt_t   = TIME_RST;
      nxt_act = 1'b1;
      nxt_bit = data_bit;
    end else if (act_ff && t_ff != TIME_SAT) begin
      nxt_t = t_ff + 17'h00001;
    end else begin
      nxt_act = 1'b0;
    end
    tt   = {1'b0, t_ff};
    d1   = {2'b00, ccfg.delay};
    d2   = d1 + {2'b00, ccfg.dbl_delay};
    ww   = {2'b00, eff_width};
    win1 = act_ff && tt >= d1 && tt < d1 + ww;
    win2 = act_ff && ccfg.dbl && tt >= d2 && tt < d2 + ww;
    nxt_out = pulse_out;
    if (tmode == TM_EXT_WIDTH) begin
      nxt_out = ext_level;
    end else if (pmode == PM_PATTERN && ccfg.nrz) begin
      if (act_ff && tt == d1) begin
        nxt_out = bit_ff;
      end
    end else if (pmode == PM_PATTERN) begin
      nxt_out = bit_ff & win1;
    end else begin
      nxt_out = win1 | win2;
    end
    if (!ccfg.en) begin
      nxt_out = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t_ff      <= TIME_RST;
      act_ff    <= 1'b0;
      bit_ff    <= 1'b0;
      pulse_out <= 1'b0;
    end else if (ce) begin
      t_ff      <= nxt_t;
      act_ff    <= nxt_act;
      bit_ff    <= nxt_bit;
      pulse_out <= nxt_out;
    end
  end

endmodule : tps_chan

//--- logic/tps_pkg.sv
// Shared types and constants of the triggered pulse and pattern sequencer.
// Assumes one 100 MHz clock; every input is synchronous to it.
package tps_pkg;

  localparam int          NUM_CH        = 2;
  localparam int          ECL_LINES     = 2;
  localparam int          TTL_LINES     = 8;
  localparam int          CNT_W         = 16;
  localparam int          TIME_W        = 17;
  localparam int          SUM_W         = 18;
  localparam int          IDX_W         = 17;
  localparam int          PAT_AW        = 14;
  localparam int          PAT_DEPTH     = 16384;
  localparam int          CLK_PERIOD_NS = 10;
  localparam logic [IDX_W-1:0]  BURST_LEN_MIN = 17'h00002;
  localparam logic [PAT_AW-1:0] PAT_LAST_MIN  = 14'h0001;
  localparam logic [IDX_W-1:0]  IDX_RST       = 17'h00000;
  localparam logic [TIME_W-1:0] TIME_RST      = 17'h00000;
  localparam logic [TIME_W-1:0] TIME_SAT      = 17'h1FFFF;
  localparam logic [CNT_W-1:0]  CNT_RST       = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE       = 16'h0001;

  typedef enum logic [1:0] {TM_TRIGGERED, TM_GATED, TM_EXT_WIDTH} tps_trig_mode_t;
  typedef enum logic [1:0] {PM_STREAM, PM_BURST, PM_PATTERN} tps_pulse_mode_t;
  typedef enum logic [1:0] {AS_EXT_IN, AS_ECL, AS_TTL, AS_PLL} tps_arm_src_t;
  typedef enum logic [1:0] {ED_RISE, ED_FALL, ED_BOTH} tps_edge_t;
  typedef enum logic [1:0] {GL_HIGH, GL_LOW, GL_ALWAYS} tps_gate_t;
  typedef enum logic [1:0] {PS_OSC, PS_PLL, PS_CLKIN} tps_period_src_t;

  typedef struct packed {
    tps_trig_mode_t   trig_mode;
    tps_pulse_mode_t  pulse_mode;
    tps_arm_src_t     arm_src;
    logic [2:0]       arm_line;
    tps_edge_t        edge_sel;
    tps_gate_t        gate_lvl;
    tps_period_src_t  period_src;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] trig_period;
    logic [IDX_W-1:0] burst_len;
    logic [PAT_AW-1:0] pat_last;
  } tps_cfg_t;

  typedef struct packed {
    logic             en;
    logic             dbl;
    logic             nrz;
    logic [CNT_W-1:0] delay;
    logic [CNT_W-1:0] dbl_delay;
    logic [CNT_W-1:0] width;
  } tps_chan_cfg_t;

  typedef struct packed {
    logic [NUM_CH-1:0] data;
    logic              strobe;
  } tps_pat_word_t;

  typedef struct packed {
    logic level;
    logic edge_hit;
    logic gate_on;
  } tps_arm_t;

endpackage : tps_pkg

//--- logic/tps_sequencer.sv
// Top of the triggered pulse and pattern sequencer: arming, period timing,
// burst and pattern sequencing, markers and the per-channel pulse shapers.
// Assumes configuration is static while running and period ticks are one-cycle pulses.
module tps_sequencer
  import tps_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  tps_cfg_t                  cfg,
  input  tps_chan_cfg_t             ch_cfg [NUM_CH],
  input  wire logic                 ext_in,
  input  wire logic [ECL_LINES-1:0] ecl_in,
  input  wire logic [TTL_LINES-1:0] ttl_in,
  input  wire logic                 pll_tick,
  input  wire logic                 clkin_tick,
  input  wire logic                 pat_we,
  input  wire logic [PAT_AW-1:0]    pat_addr,
  input  tps_pat_word_t             pat_wdata,
  output logic [NUM_CH-1:0]         ch_out,
  output logic                      trig_out,
  output logic                      strobe_out,
  output logic                      busy,
  output logic                      cfg_err
);

  typedef enum logic {ST_IDLE, ST_RUN} tps_state_t;

  tps_state_t        state_ff;
  tps_state_t        nxt_state;
  logic [CNT_W-1:0]  per_cnt_ff;
  logic [CNT_W-1:0]  nxt_per_cnt;
  logic [IDX_W-1:0]  nidx_ff;
  logic [IDX_W-1:0]  nxt_nidx;
  logic              pend_ff;
  logic              nxt_pend;
  logic              trig_ff;
  logic              nxt_trig;
  logic              strobe_ff;
  logic              nxt_strobe;
  logic              err_ff;
  logic              nxt_err;
  logic [NUM_CH-1:0] data_ff;
  logic [NUM_CH-1:0] nxt_data;

  tps_pat_word_t     pat_mem [PAT_DEPTH];
  tps_pat_word_t     pat_rd;
  tps_arm_t          arm;
  logic [CNT_W-1:0]  eff_period;
  logic [CNT_W-1:0]  eff_width [NUM_CH];
  logic [IDX_W-1:0]  last_idx;
  logic [IDX_W-1:0]  cur_idx;
  logic              gen_ok;
  logic              trig_mode;
  logic              src_tick;
  logic              period_end;
  logic              want;
  logic              pstart;

  tps_arm_sel u_arm (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .ext_in (ext_in),
    .ecl_in (ecl_in),
    .ttl_in (ttl_in),
    .cfg    (cfg),
    .arm    (arm)
  );

  // Enabled widths are only compared, never rewritten, so a later period or delay
  // change leaves the programmed width as it was.
  always_comb begin
    eff_period = (cfg.period == CNT_RST) ? CNT_ONE : cfg.period;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_cfg[i].en && ch_cfg[i].width > eff_period) begin
        eff_period = ch_cfg[i].width;
      end
    end
    for (int i = 0; i < NUM_CH; i++) begin
      eff_width[i] = (ch_cfg[i].width > eff_period) ? eff_period : ch_cfg[i].width;
    end
  end

  always_comb begin
    last_idx = IDX_RST;
    if (cfg.pulse_mode == PM_BURST) begin
      last_idx = ((cfg.burst_len < BURST_LEN_MIN) ? BURST_LEN_MIN : cfg.burst_len) - 17'h00001;
    end else if (cfg.pulse_mode == PM_PATTERN) begin
      last_idx = {3'b000, (cfg.pat_last < PAT_LAST_MIN) ? PAT_LAST_MIN : cfg.pat_last};
    end
  end

  always_comb begin
    nxt_err   = (cfg.period_src == PS_PLL) && (cfg.arm_src == AS_PLL);
    gen_ok    = !err_ff && cfg.trig_mode != TM_EXT_WIDTH;
    trig_mode = cfg.trig_mode == TM_TRIGGERED;
    // Ticks from the PLL or the clock input are not aligned to arming, so a
    // start waits for the next tick; only the oscillator restarts on the spot.
    case (cfg.period_src)
      PS_PLL:   src_tick = pll_tick;
      PS_CLKIN: src_tick = clkin_tick;
      default:  src_tick = 1'b0;
    endcase
    if (cfg.period_src == PS_OSC) begin
      period_end = per_cnt_ff + CNT_ONE >= eff_period;
    end else begin
      period_end = src_tick;
    end
    if (trig_mode) begin
      want = pend_ff | arm.edge_hit;
    end else begin
      want = arm.gate_on;
    end
    nxt_state = state_ff;
    pstart    = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (gen_ok && want && (cfg.period_src == PS_OSC || src_tick)) begin
          pstart    = 1'b1;
          nxt_state = ST_RUN;
        end
      end
      default: begin
        if (period_end) begin
          // A closing gate is only looked at here, so a period in progress
          // always completes and no pulse is cut short.
          if (gen_ok && ((trig_mode && nidx_ff != IDX_RST) || want)) begin
            pstart = 1'b1;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_comb begin
    cur_idx = nidx_ff;
    if ((state_ff == ST_IDLE && trig_mode) || nidx_ff > last_idx) begin
      cur_idx = IDX_RST;
    end
    pat_rd      = pat_mem[cur_idx[PAT_AW-1:0]];
    nxt_nidx    = nidx_ff;
    nxt_per_cnt = per_cnt_ff + CNT_ONE;
    nxt_trig    = pstart;
    nxt_strobe  = strobe_ff;
    nxt_data    = data_ff;
    // Only one pending edge is kept; an edge in the consuming cycle survives.
    nxt_pend = trig_mode ? (pend_ff | arm.edge_hit) : 1'b0;
    if (pstart) begin
      nxt_per_cnt = CNT_RST;
      nxt_nidx    = (cur_idx == last_idx) ? IDX_RST : cur_idx + 17'h00001;
      if (trig_mode && cur_idx == IDX_RST) begin
        nxt_pend = pend_ff & arm.edge_hit;
      end
      if (cfg.pulse_mode == PM_PATTERN) begin
        nxt_strobe = pat_rd.strobe;
        nxt_data   = pat_rd.data;
      end else begin
        nxt_data = {NUM_CH{1'b1}};
        if (cfg.pulse_mode == PM_BURST && cur_idx == IDX_RST) begin
          nxt_strobe = 1'b1;
        end else if (cfg.pulse_mode == PM_BURST && cur_idx == last_idx) begin
          nxt_strobe = 1'b0;
        end
      end
    end
    if (cfg.pulse_mode == PM_STREAM || cfg.trig_mode == TM_EXT_WIDTH) begin
      nxt_strobe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && pat_we) begin
      pat_mem[pat_addr] <= pat_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      per_cnt_ff <= CNT_RST;
      nidx_ff    <= IDX_RST;
      pend_ff    <= 1'b0;
      trig_ff    <= 1'b0;
      strobe_ff  <= 1'b0;
      err_ff     <= 1'b0;
      data_ff    <= '0;
    end else if (ce) begin
      state_ff   <= nxt_state;
      per_cnt_ff <= nxt_per_cnt;
      nidx_ff    <= nxt_nidx;
      pend_ff    <= nxt_pend;
      trig_ff    <= nxt_trig;
      strobe_ff  <= nxt_strobe;
      err_ff     <= nxt_err;
      data_ff    <= nxt_data;
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    tps_chan u_chan (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .pstart    (trig_ff),
      .data_bit  (data_ff[g]),
      .ext_level (arm.level),
      .ccfg      (ch_cfg[g]),
      .eff_width (eff_width[g]),
      .pmode     (cfg.pulse_mode),
      .tmode     (cfg.trig_mode),
      .pulse_out (ch_out[g])
    );
  end

  assign trig_out   = trig_ff;
  assign strobe_out = strobe_ff;
  assign busy       = state_ff == ST_RUN;
  assign cfg_err    = err_ff;

endmodule : tps_sequencer

//--- verif/tps_far_end.sv
// Far-side model: drives the arming lines and counts marks and output pulses.
// Assumes outputs come from flops, so sampling on the rising edge reads settled values.
module tps_far_end
  import tps_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [NUM_CH-1:0]    ch_out,
  input  wire logic                 trig_out,
  input  wire logic                 strobe_out,
  output logic                      ext_in,
  output logic [ECL_LINES-1:0]      ecl_in,
  output logic [TTL_LINES-1:0]      ttl_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int trig_n;
  int stb_n;
  int rise_n [NUM_CH];
  int hi_n [NUM_CH];
  logic [NUM_CH-1:0] ch_q;
  task automatic clr();
    trig_n = 0;
    stb_n = 0;
    rise_n = '{0, 0};
    hi_n = '{0, 0};
  endtask : clr
  initial begin
    ext_in = 1'b0;
    ecl_in = '0;
    ttl_in = '0;
    ch_q = '0;
    clr();
  end
  always @(posedge clk) begin
    trig_n += int'(trig_out);
    stb_n += int'(strobe_out);
    for (int i = 0; i < NUM_CH; i++) begin
      rise_n[i] += int'(ch_out[i] && !ch_q[i]);
      hi_n[i] += int'(ch_out[i]);
    end
    ch_q <= ch_out;
  end
  // Lines move only on the falling edge so the sampling edge never races them.
  task automatic drive(input int src, input int ln, input logic v);
    @(negedge clk);
    case (src)
      0: ext_in = v;
      1: ecl_in[ln] = v;
      default: ttl_in[ln] = v;
    endcase
  endtask : drive
  task automatic pulse(input int src, input int ln, input int hi, input int lo);
    drive(src, ln, 1'b1);
    repeat (hi) @(negedge clk);
    drive(src, ln, 1'b0);
    repeat (lo) @(negedge clk);
  endtask : pulse
endmodule : tps_far_end

//--- verif/tps_sequencer_sva.sv
// Checker of the sequencer top: marker, rejection and external-width timing.
// Assumes one clock domain, a synchronous active-high reset and ce held high.
module tps_sequencer_sva
  import tps_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  tps_cfg_t               cfg,
  input  tps_chan_cfg_t          ch_cfg [NUM_CH],
  input  wire logic              ext_in,
  input  wire logic [NUM_CH-1:0] ch_out,
  input  wire logic              trig_out,
  input  wire logic              strobe_out,
  input  wire logic              busy,
  input  wire logic              cfg_err
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic both_pll;
  logic gate_hi;
  assign both_pll = (cfg.period_src == PS_PLL) && (cfg.arm_src == AS_PLL);
  assign gate_hi = (cfg.trig_mode == TM_GATED) && (cfg.gate_lvl == GL_HIGH) && (cfg.arm_src == AS_EXT_IN)
                   && (cfg.period_src == PS_OSC) && !cfg_err;
  sequence osc_rise;
    cfg.trig_mode == TM_TRIGGERED && cfg.pulse_mode == PM_STREAM && cfg.arm_src == AS_EXT_IN
      && cfg.period_src == PS_OSC && cfg.edge_sel == ED_RISE && !busy && !cfg_err && $rose(ext_in);
  endsequence
  sequence ext_w;
    cfg.trig_mode == TM_EXT_WIDTH && cfg.arm_src == AS_EXT_IN && ch_cfg[0].en;
  endsequence
  sequence in_burst;
    cfg.pulse_mode == PM_BURST [*2];
  endsequence
  trig_start_a: assert property (osc_rise |=> trig_out) else $error("trigger edge gave no period mark");
  pll_rej_a: assert property (both_pll |=> cfg_err) else $error("pll double use not rejected");
  pll_ok_a: assert property (!both_pll |=> !cfg_err) else $error("config error without cause");
  rej_start_a: assert property (cfg_err && !busy |=> !trig_out) else $error("period started while rejected");
  mark_busy_a: assert property (trig_out |-> busy) else $error("period mark outside a sequence");
  stb_rise_a: assert property (in_burst ##0 $rose(strobe_out) |-> trig_out) else $error("strobe rose off start");
  stb_fall_a: assert property (in_burst ##0 $fell(strobe_out) |-> trig_out) else $error("strobe fell off start");
  strm_stb_a: assert property (cfg.pulse_mode == PM_STREAM [*2] |-> !strobe_out) else $error("strobe in stream");
  gate_run_a: assert property (gate_hi && !busy |=> trig_out == $past(ext_in)) else $error("gate level ignored");
  extw_lag_a: assert property (ext_w [*2] |-> ch_out[0] == $past(ext_in)) else $error("width output lag wrong");
  extw_idle_a: assert property (ext_w [*2] |-> !trig_out) else $error("period mark in external width");
endmodule : tps_sequencer_sva

bind tps_sequencer tps_sequencer_sva u_sva (.clk(clk), .rst(rst), .cfg(cfg), .ch_cfg(ch_cfg), .ext_in(ext_in),
  .ch_out(ch_out), .trig_out(trig_out), .strobe_out(strobe_out), .busy(busy), .cfg_err(cfg_err));

//--- verif/tps_sequencer_tb.sv
// Self-checking bench of the sequencer top, one task per group of related scenarios.
// Assumes the far-end model drives the arming lines and counts the outputs.
module tps_sequencer_tb
  import tps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clk;
  logic                 rst;
  logic                 pll_tick = 1'b0;
  logic                 clkin_tick = 1'b0;
  logic                 pat_we;
  logic [PAT_AW-1:0]    pat_addr;
  tps_pat_word_t        pat_wdata;
  tps_cfg_t             cfg;
  tps_chan_cfg_t        ch_cfg [NUM_CH];
  logic                 ext_in;
  logic [ECL_LINES-1:0] ecl_in;
  logic [TTL_LINES-1:0] ttl_in;
  logic [NUM_CH-1:0]    ch_out;
  logic                 trig_out, strobe_out, busy, cfg_err;
  int                   num_errors = 0, n_compared = 0, cyc = 0;
  tps_sequencer dut (.clk(clk), .rst(rst), .ce(1'b1), .cfg(cfg), .ch_cfg(ch_cfg), .ext_in(ext_in), .ecl_in(ecl_in),
    .ttl_in(ttl_in), .pll_tick(pll_tick), .clkin_tick(clkin_tick), .pat_we(pat_we), .pat_addr(pat_addr),
    .pat_wdata(pat_wdata), .ch_out(ch_out), .trig_out(trig_out), .strobe_out(strobe_out), .busy(busy),
    .cfg_err(cfg_err));
  tps_far_end far (.clk(clk), .ch_out(ch_out), .trig_out(trig_out), .strobe_out(strobe_out), .ext_in(ext_in),
    .ecl_in(ecl_in), .ttl_in(ttl_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  // The ceiling is over ten times the fewer than 700 cycles the scenarios need.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      final_report();
    end
  end
  always @(negedge clk) pll_tick <= (cyc % 5 == 0);
  // The clock-input ticks run on a different beat so the two sources never look alike.
  always @(negedge clk) clkin_tick <= (cyc % 7 == 3);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic setup(input tps_trig_mode_t tm, input tps_pulse_mode_t pm);
    @(negedge clk);
    cfg = '{tm, pm, AS_EXT_IN, 3'h0, ED_RISE, GL_HIGH, PS_OSC, 16'h0004, 16'h0014, 17'h00002, 14'h0001};
    ch_cfg[0] = '{1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0002};
    ch_cfg[1] = '{1'b1, 1'b1, 1'b0, 16'h0000, 16'h0002, 16'h0001};
    far.clr();
  endtask : setup
  task automatic t_edges();
    int n;
    for (int e = 0; e < 3; e++) begin
      setup(TM_TRIGGERED, PM_STREAM);
      cfg.edge_sel = tps_edge_t'(e);
      n = (e == 2) ? 2 : 1;
      far.pulse(0, 0, 0, 14);
      chk(far.trig_n, n);
      chk(far.rise_n[0], n);
      chk(far.hi_n[0], 2 * n);
      chk(far.rise_n[1], 2 * n);
    end
    setup(TM_TRIGGERED, PM_STREAM);
    cfg.period = 16'h0001;
    ch_cfg[0].delay = 16'h0003;
    far.pulse(0, 0, 0, 14);
    chk(far.trig_n, 1);
    chk(far.hi_n[0], 2);
    $display("edges done");
  endtask : t_edges
  task automatic t_sources();
    for (int s = 0; s < ECL_LINES + TTL_LINES; s++) begin
      setup(TM_TRIGGERED, PM_STREAM);
      cfg.arm_src = (s < ECL_LINES) ? AS_ECL : AS_TTL;
      cfg.arm_line = 3'((s < ECL_LINES) ? s : s - ECL_LINES);
      far.pulse(0, 0, 2, 6);
      far.pulse((s < ECL_LINES) ? 1 : 2, int'(cfg.arm_line), 2, 8);
      chk(far.trig_n, 1);
    end
    $display("sources done");
  endtask : t_sources
  task automatic t_burst();
    for (int len = 2; len < 4; len++) begin
      setup(TM_TRIGGERED, PM_BURST);
      cfg.burst_len = 17'(len);
      far.pulse(0, 0, 2, 4 * len + 8);
      chk(far.trig_n, len);
      chk(far.stb_n, 4 * (len - 1));
    end
    $display("burst done");
  endtask : t_burst
  task automatic t_pattern();
    logic [2:0] w [4] = '{3'h2, 3'h5, 3'h7, 3'h2};
    setup(TM_TRIGGERED, PM_PATTERN);
    cfg.pat_last = 14'h0003;
    ch_cfg[1] = '{1'b1, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0001};
    for (int i = 0; i < 4; i++) begin
      pat_we = 1'b1;
      pat_addr = 14'(i);
      pat_wdata = w[i];
      @(negedge clk);
    end
    pat_we = 1'b0;
    far.pulse(0, 0, 2, 24);
    chk(far.trig_n, 4);
    chk(far.rise_n[0], 3);
    chk(far.rise_n[1], 1);
    chk(far.hi_n[1], 8);
    chk(far.stb_n, 8);
    $display("pattern done");
  endtask : t_pattern
  task automatic t_gated();
    setup(TM_GATED, PM_STREAM);
    far.pulse(0, 0, 9, 12);
    chk(far.trig_n, 3);
    chk(far.hi_n[0], 6);
    setup(TM_TRIGGERED, PM_STREAM);
    far.drive(0, 0, 1'b1);
    repeat (10) @(negedge clk);
    setup(TM_GATED, PM_PATTERN);
    cfg.gate_lvl = GL_LOW;
    repeat (9) @(negedge clk);
    chk(far.trig_n, 0);
    far.drive(0, 0, 1'b0);
    repeat (9) @(negedge clk);
    far.drive(0, 0, 1'b1);
    repeat (12) @(negedge clk);
    chk(far.trig_n, 3);
    setup(TM_GATED, PM_BURST);
    cfg.gate_lvl = GL_ALWAYS;
    repeat (16) @(negedge clk);
    chk({31'h0, far.trig_n >= 3 && far.stb_n > 0}, 32'h1);
    setup(TM_TRIGGERED, PM_STREAM);
    repeat (12) @(negedge clk);
    far.drive(0, 0, 1'b0);
    $display("gated done");
  endtask : t_gated
  task automatic t_misc();
    setup(TM_EXT_WIDTH, PM_STREAM);
    far.pulse(0, 0, 4, 6);
    chk(far.trig_n, 0);
    chk(far.hi_n[0], 5);
    setup(TM_TRIGGERED, PM_BURST);
    cfg.arm_src = AS_PLL;
    repeat (60) @(negedge clk);
    chk({31'h0, far.trig_n >= 4 && far.trig_n <= 6}, 32'h1);
    cfg.period_src = PS_PLL;
    repeat (3) @(negedge clk);
    chk(cfg_err, 32'h1);
    setup(TM_TRIGGERED, PM_STREAM);
    cfg.period_src = PS_PLL;
    far.pulse(0, 0, 2, 30);
    chk(cfg_err, 32'h0);
    chk(far.trig_n, 1);
    setup(TM_TRIGGERED, PM_STREAM);
    cfg.period_src = PS_CLKIN;
    far.pulse(0, 0, 2, 30);
    chk(far.trig_n, 1);
    $display("misc done");
  endtask : t_misc
  initial begin
    rst = 1'b1;
    pat_we = 1'b0;
    pat_addr = '0;
    pat_wdata = '0;
    cfg = '0;
    ch_cfg = '{default: '0};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_edges();
    t_sources();
    t_burst();
    t_pattern();
    t_gated();
    t_misc();
    final_report();
  end
endmodule : tps_sequencer_tb
